// ==== core/ess_defs.svh ====
// Purpose: Constants for the sync loss supervisor.
// Assumes: 40 MHz tick units for intervals, block clocked at 250 MHz.
// Notes: Definitions only.
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH
`define ESS_CLK_MHZ 250
`define ESS_TICK_MHZ 40
`define ESS_INTERVAL_W 32
`define ESS_COUNT_W 16
`define ESS_POS_W 32
`define ESS_FILT_W 8
`define ESS_GAP_NUM 3
`define ESS_GAP_DEN 2
`define ESS_ERR_MISSING 0
`define ESS_ERR_EXTRA 1
`define ESS_ERR_CAM 2
`define ESS_ERR_W 3
`endif

// ==== core/ess_pkg.sv ====
// Purpose: Types for the sync loss supervisor.
// Assumes: Constants live in ess_defs.svh.
// Notes: No constants here.
package ess_pkg;
    typedef enum logic [1:0] {
        ESS_ST_STALLED = 2'b00,
        ESS_ST_COUNT = 2'b01,
        ESS_ST_SEARCH = 2'b10,
        ESS_ST_SYNC = 2'b11
    } ess_state_t;
endpackage

// ==== core/ess_edge_if.sv ====
// Purpose: Carries one filtered input level and its rising edge pulse.
// Assumes: Single clock domain.
// Notes: Filter drives, supervisor reads.
`timescale 1ns/10ps
`default_nettype none
interface ess_edge_if;
    logic level;
    logic rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface
`default_nettype wire

// ==== core/ess_glitch_filter.sv ====
// Purpose: Synchronises and integrates one pulse input, rejects short glitches.
// Assumes: Pulse input is asynchronous to ref_clk.
// Notes: Width zero passes the synchronised level straight through.
`timescale 1ns/10ps
`default_nettype none
`include "ess_defs.svh"
module ess_glitch_filter #(
    parameter int FW = `ESS_FILT_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic pin_in,
    input wire logic filt_en,
    input wire logic [FW-1:0] filt_width,
    ess_edge_if.src out
);
    logic sync1_r;
    logic sync2_r;
    logic lvl_r;
    logic [FW-1:0] integ_r;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // The integrator follows the input only after it holds longer than the width.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            integ_r <= '0;
            lvl_r <= 1'b0;
            out.rise <= 1'b0;
        end else if (clk_en) begin
            out.rise <= 1'b0;
            if (!filt_en || filt_width == '0) begin
                lvl_r <= sync2_r;
                out.rise <= sync2_r & ~lvl_r;
                integ_r <= '0;
            end else if (sync2_r == lvl_r) begin
                integ_r <= '0;
            end else if (integ_r >= filt_width) begin
                lvl_r <= sync2_r;
                out.rise <= sync2_r;
                integ_r <= '0;
            end else begin
                integ_r <= integ_r + 1'b1;
            end
        end
    end

    assign out.level = lvl_r;
endmodule
`default_nettype wire

// ==== core/ess_supervisor.sv ====
// Purpose: Loss of sync and stall supervision for an engine position tracker.
// Assumes: Tooth intervals counted in 40 MHz ticks, derived from a 250 MHz clock.
// Notes: Simplified tooth pattern: N evenly spaced teeth with one gap, cam pulse per cycle.
`timescale 1ns/10ps
`default_nettype none
`include "ess_defs.svh"
module ess_supervisor #(
    parameter int IW = `ESS_INTERVAL_W,
    parameter int CW = `ESS_COUNT_W,
    parameter int PW = `ESS_POS_W,
    parameter int FW = `ESS_FILT_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic crank_pulse_in,
    input wire logic cam_pulse_in,
    input wire logic filter_enable,
    input wire logic [FW-1:0] filter_width,
    input wire logic tracking_allow,
    input wire logic [IW-1:0] stall_interval_limit,
    input wire logic [CW-1:0] start_tooth_count,
    input wire logic [CW-1:0] teeth_per_cycle,
    input wire logic [CW-1:0] accum_tooth_count,
    input wire logic [PW-1:0] ticks_per_tooth,
    input wire logic error_flag_clear_req,
    output logic [CW-1:0] crank_tooth_index,
    output logic [PW-1:0] angle_tick_position,
    output logic [IW-1:0] tooth_interval,
    output logic [IW-1:0] accumulated_tooth_interval,
    output logic sync_lost_indicator,
    output logic stall_indicator,
    output logic [`ESS_ERR_W-1:0] pattern_error_flag
);
    ess_edge_if crank_if();
    ess_edge_if cam_if();

    ess_glitch_filter #(.FW(FW)) u_crank_filt (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .pin_in(crank_pulse_in),
        .filt_en(filter_enable),
        .filt_width(filter_width),
        .out(crank_if)
    );

    ess_glitch_filter #(.FW(FW)) u_cam_filt (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .pin_in(cam_pulse_in),
        .filt_en(filter_enable),
        .filt_width(filter_width),
        .out(cam_if)
    );

    ess_pkg::ess_state_t state_r;
    logic [7:0] tick_div_r;
    logic tick_en;
    logic [8:0] tick_sum;
    logic [IW-1:0] run_cnt_r;
    logic [IW-1:0] last_int_r;
    logic [IW-1:0] acc_sum_r;
    logic [CW-1:0] acc_teeth_r;
    logic [CW-1:0] start_cnt_r;
    logic [CW-1:0] phys_idx_r;
    logic cam_seen_r;
    logic stall_now;
    logic is_gap;
    logic gap_expected;
    logic err_missing;
    logic err_extra;
    logic err_cam;
    logic mismatch;

    // Interval exceeds the previous interval by the 3/2 gap ratio: read as the missing tooth gap.
    function automatic logic over_gap(input logic [IW-1:0] cur, input logic [IW-1:0] ref_i);
        logic [IW+1:0] lhs;
        logic [IW+1:0] rhs;
        lhs = {2'b00, cur} * (IW+2)'(`ESS_GAP_DEN);
        rhs = {2'b00, ref_i} * (IW+2)'(`ESS_GAP_NUM);
        return (ref_i != '0) && (lhs > rhs);
    endfunction

    // Accumulates 40 MHz ticks from the 250 MHz clock: 40 per 250 cycles.
    // The sum is one bit wider so that a carry past 255 is never lost.
    assign tick_sum = {1'b0, tick_div_r} + 9'(`ESS_TICK_MHZ);
    assign tick_en = (tick_sum >= 9'(`ESS_CLK_MHZ));
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tick_div_r <= 8'h00;
        end else if (clk_en) begin
            if (tick_en) begin
                tick_div_r <= 8'(tick_sum - 9'(`ESS_CLK_MHZ));
            end else begin
                tick_div_r <= tick_sum[7:0];
            end
        end
    end

    assign stall_now = (run_cnt_r > stall_interval_limit);
    assign is_gap = crank_if.rise && over_gap(run_cnt_r, last_int_r);
    assign gap_expected = (phys_idx_r == teeth_per_cycle - 2'd2);
    assign err_missing = (state_r == ess_pkg::ESS_ST_SYNC) && is_gap && !gap_expected;
    assign err_extra = (state_r == ess_pkg::ESS_ST_SYNC) && crank_if.rise && !is_gap
        && gap_expected;
    assign err_cam = (state_r == ess_pkg::ESS_ST_SYNC) && is_gap && gap_expected
        && !cam_seen_r;
    assign mismatch = err_missing | err_extra | err_cam;

    // Measures the running crank interval in 40 MHz ticks.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            run_cnt_r <= '0;
            last_int_r <= '0;
        end else if (clk_en) begin
            if (crank_if.rise) begin
                run_cnt_r <= '0;
                last_int_r <= stall_now ? '0 : run_cnt_r;
            end else if (tick_en && !stall_now) begin
                run_cnt_r <= run_cnt_r + 1'b1;
            end
        end
    end

    // Sync state sequence.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= ess_pkg::ESS_ST_STALLED;
            start_cnt_r <= '0;
        end else if (clk_en) begin
            if (!tracking_allow || stall_now) begin
                state_r <= ess_pkg::ESS_ST_STALLED;
                start_cnt_r <= '0;
            end else begin
                case (state_r)
                    ess_pkg::ESS_ST_STALLED: begin
                        if (crank_if.rise) begin
                            state_r <= ess_pkg::ESS_ST_COUNT;
                        end
                    end
                    ess_pkg::ESS_ST_COUNT: begin
                        if (crank_if.rise) begin
                            start_cnt_r <= start_cnt_r + 1'b1;
                            if (start_cnt_r + 1'b1 >= start_tooth_count) begin
                                state_r <= ess_pkg::ESS_ST_SEARCH;
                            end
                        end
                    end
                    ess_pkg::ESS_ST_SEARCH: begin
                        if (is_gap) begin
                            state_r <= ess_pkg::ESS_ST_SYNC;
                        end
                    end
                    ess_pkg::ESS_ST_SYNC: begin
                        if (mismatch) begin
                            state_r <= ess_pkg::ESS_ST_STALLED;
                            start_cnt_r <= '0;
                        end
                    end
                    default: state_r <= ess_pkg::ESS_ST_STALLED;
                endcase
            end
        end
    end

    // Physical tooth position and cam observation within the cycle.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            phys_idx_r <= '0;
            cam_seen_r <= 1'b0;
        end else if (clk_en) begin
            if (state_r != ess_pkg::ESS_ST_SYNC || mismatch || (is_gap && gap_expected)) begin
                phys_idx_r <= '0;
                cam_seen_r <= cam_if.rise;
            end else begin
                if (crank_if.rise) begin
                    phys_idx_r <= phys_idx_r + 1'b1;
                end
                if (cam_if.rise) begin
                    cam_seen_r <= 1'b1;
                end
            end
        end
    end

    // Tooth index and angle outputs, zero whenever sync is lost.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            crank_tooth_index <= '0;
            angle_tick_position <= '0;
        end else if (clk_en) begin
            if (state_r != ess_pkg::ESS_ST_SYNC || mismatch || stall_now || !tracking_allow) begin
                crank_tooth_index <= '0;
                angle_tick_position <= '0;
            end else if (is_gap) begin
                crank_tooth_index <= '0;
                angle_tick_position <= '0;
            end else if (crank_if.rise) begin
                crank_tooth_index <= crank_tooth_index + 1'b1;
                angle_tick_position <= angle_tick_position + ticks_per_tooth;
            end
        end
    end

    // Interval outputs, zero while stalled.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tooth_interval <= '0;
            accumulated_tooth_interval <= '0;
            acc_sum_r <= '0;
            acc_teeth_r <= '0;
        end else if (clk_en) begin
            if (stall_now) begin
                tooth_interval <= '0;
                accumulated_tooth_interval <= '0;
                acc_sum_r <= '0;
                acc_teeth_r <= '0;
            end else if (crank_if.rise && !is_gap) begin
                tooth_interval <= run_cnt_r;
                if (acc_teeth_r + 1'b1 >= accum_tooth_count) begin
                    accumulated_tooth_interval <= acc_sum_r + run_cnt_r;
                    acc_sum_r <= '0;
                    acc_teeth_r <= '0;
                end else begin
                    acc_sum_r <= acc_sum_r + run_cnt_r;
                    acc_teeth_r <= acc_teeth_r + 1'b1;
                end
            end
        end
    end

    // Status indicators and latched error flags; a new error wins over clear.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync_lost_indicator <= 1'b1;
            stall_indicator <= 1'b1;
            pattern_error_flag <= '0;
        end else if (clk_en) begin
            sync_lost_indicator <= (state_r != ess_pkg::ESS_ST_SYNC) || mismatch
                || stall_now || !tracking_allow;
            stall_indicator <= stall_now;
            pattern_error_flag <= (error_flag_clear_req ? '0 : pattern_error_flag)
                | {err_cam, err_extra, err_missing};
        end
    end
endmodule
`default_nettype wire

// ==== bench/ess_supervisor_properties.sv ====
// Purpose: Concurrent checks on the sync loss supervisor ports.
// Assumes: One clock, synchronous active low reset.
// Notes: Bound to every supervisor instance.
`timescale 1ns/10ps
`default_nettype none
`include "ess_defs.svh"
module ess_supervisor_checker #(
    parameter int IW = 32,
    parameter int CW = 16,
    parameter int PW = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic tracking_allow,
    input wire logic [IW-1:0] stall_interval_limit,
    input wire logic error_flag_clear_req,
    input wire logic [CW-1:0] crank_tooth_index,
    input wire logic [PW-1:0] angle_tick_position,
    input wire logic [IW-1:0] tooth_interval,
    input wire logic [IW-1:0] accumulated_tooth_interval,
    input wire logic sync_lost_indicator,
    input wire logic stall_indicator,
    input wire logic [`ESS_ERR_W-1:0] pattern_error_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    lost_zeroes_a: assert property (sync_lost_indicator |->
        crank_tooth_index == '0 && angle_tick_position == '0) else $error("unsynced index not zero");
    stall_zeroes_a: assert property (stall_indicator |->
        tooth_interval == '0 && accumulated_tooth_interval == '0) else $error("stalled interval set");
    stall_drops_a: assert property (stall_indicator |-> sync_lost_indicator)
        else $error("stalled while in sync");
    limit_held_a: assert property (tooth_interval <= stall_interval_limit)
        else $error("interval above stall limit");
    error_drops_a: assert property ((pattern_error_flag & ~$past(pattern_error_flag)) != '0
        |-> sync_lost_indicator) else $error("error flag without sync loss");
    flags_sticky_a: assert property (!$past(error_flag_clear_req) |->
        (pattern_error_flag & $past(pattern_error_flag)) == $past(pattern_error_flag))
        else $error("error flag dropped without clear");
    restart_allowed_a: assert property ($fell(sync_lost_indicator) |-> $past(tracking_allow))
        else $error("sync gained while not allowed");
    restart_unstalled_a: assert property ($fell(sync_lost_indicator) |-> !stall_indicator)
        else $error("sync gained while stalled");
    blocked_stays_a: assert property (sync_lost_indicator && !tracking_allow
        |=> sync_lost_indicator [*3]) else $error("sync gained while blocked");
endmodule
bind ess_supervisor ess_supervisor_checker #(.IW(IW), .CW(CW), .PW(PW)) i_ess_supervisor_checker (
    .ref_clk, .rstn, .tracking_allow, .stall_interval_limit, .error_flag_clear_req,
    .crank_tooth_index, .angle_tick_position, .tooth_interval, .accumulated_tooth_interval,
    .sync_lost_indicator, .stall_indicator, .pattern_error_flag);
`default_nettype wire

// ==== bench/ess_wheel_model.sv ====
// Purpose: Crank and cam trigger wheel sensor model.
// Assumes: N teeth with the last one missing, one cam pulse per cycle.
// Notes: Lines stay low while the wheel stands still.
`timescale 1ns/10ps
`default_nettype none
module ess_wheel_model #(
    parameter int P = 40
) (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic [15:0] teeth,
    input wire logic skip,
    input wire logic no_cam,
    input wire logic glitch,
    input wire logic fill,
    output logic crank,
    output logic cam
);
    logic [15:0] cyc_r;
    logic [15:0] pos_r;
    always_ff @(posedge ref_clk) begin
        if (!run || cyc_r == 16'(P - 1)) cyc_r <= '0;
        else cyc_r <= cyc_r + 16'h0001;
    end
    always_ff @(posedge ref_clk) begin
        if (!run) pos_r <= '0;
        else if (cyc_r == 16'(P - 1)) pos_r <= (pos_r == teeth - 16'h0001) ? '0 : pos_r + 16'h0001;
    end
    always_comb begin
        crank = run && cyc_r < 16'(P / 2) && (pos_r != teeth - 16'h0001 || fill);
        crank = crank && !(skip && pos_r == 16'h0002);
        crank = crank || (glitch && (cyc_r == 16'(P * 3 / 4) || cyc_r == 16'(P * 3 / 4 + 1)));
        cam = run && !no_cam && pos_r == (teeth >> 1) && cyc_r < 16'(P / 2);
    end
endmodule
`default_nettype wire

// ==== bench/ess_supervisor_tb_top.sv ====
// Purpose: Self-checking bench for the sync loss supervisor.
// Assumes: Inputs change at the falling clock edge.
// Notes: Tooth period 40 clocks, stall limit 100 ticks.
`timescale 1ns/10ps
`default_nettype none
`include "ess_defs.svh"
module ess_supervisor_tb_top;
    localparam int P = 40;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic run = 1'b0;
    logic tracking_allow = 1'b1;
    logic filter_enable = 1'b0;
    logic error_flag_clear_req = 1'b0;
    logic skip = 1'b0;
    logic no_cam = 1'b0;
    logic glitch = 1'b0;
    logic fill = 1'b0;
    logic [31:0] stall_limit = 32'h00000064;
    logic [15:0] teeth = 16'h0008;
    logic crank;
    logic cam;
    logic [15:0] crank_tooth_index;
    logic [31:0] angle_tick_position;
    logic [31:0] tooth_interval;
    logic [31:0] accumulated_tooth_interval;
    logic sync_lost_indicator;
    logic stall_indicator;
    logic [`ESS_ERR_W-1:0] pattern_error_flag;
    int fail_count = 0;
    int checks_done = 0;
    always #2 ref_clk = ~ref_clk;
    ess_wheel_model #(.P(P)) i_ess_wheel_model (.ref_clk, .run, .teeth, .skip, .no_cam,
        .glitch, .fill, .crank, .cam);
    ess_supervisor i_ess_supervisor (.ref_clk, .rstn, .clk_en(1'b1), .crank_pulse_in(crank),
        .cam_pulse_in(cam), .filter_enable, .filter_width(8'h04), .tracking_allow,
        .stall_interval_limit(stall_limit), .start_tooth_count(16'h0002),
        .teeth_per_cycle(teeth), .accum_tooth_count(16'h0008), .ticks_per_tooth(32'h00000080),
        .error_flag_clear_req, .crank_tooth_index, .angle_tick_position, .tooth_interval,
        .accumulated_tooth_interval, .sync_lost_indicator, .stall_indicator, .pattern_error_flag);
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wait_lost(input logic want);
        int n;
        n = 0;
        while (sync_lost_indicator !== want && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        check("sync_lost_indicator", {31'h0, want}, {31'h0, sync_lost_indicator});
    endtask
    task automatic wait_pos(input logic [15:0] v);
        int n;
        n = 0;
        while (i_ess_wheel_model.pos_r !== v && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        check("wheel_position", {16'h0, v}, {16'h0, i_ess_wheel_model.pos_r});
    endtask
    task automatic revs(input int r);
        repeat (r * 8 * P) @(negedge ref_clk);
    endtask
    task automatic clear_flags;
        error_flag_clear_req = 1'b1;
        @(negedge ref_clk);
        error_flag_clear_req = 1'b0;
        check("pattern_error_flag", 32'h0, {29'h0, pattern_error_flag});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        $display("FAIL watchdog expected finish seen timeout");
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        check("sync_lost_indicator", 32'h1, {31'h0, sync_lost_indicator});
        check("pattern_error_flag", 32'h0, {29'h0, pattern_error_flag});
        rstn = 1'b1;
        repeat (800) @(negedge ref_clk);
        check("stall_indicator", 32'h1, {31'h0, stall_indicator});
        check("tooth_interval", 32'h0, tooth_interval);
        check("accumulated_tooth_interval", 32'h0, accumulated_tooth_interval);
        $display("test stall finished");
        run = 1'b1;
        wait_lost(1'b0);
        repeat (2 * P) @(negedge ref_clk);
        check("stall_indicator", 32'h0, {31'h0, stall_indicator});
        check("interval_6_or_7", 32'h1, {31'h0, tooth_interval inside {6, 7}});
        wait_pos(16'h0003);
        repeat (10) @(negedge ref_clk);
        check("crank_tooth_index", 32'h3, {16'h0, crank_tooth_index});
        check("angle_tick_position", 32'h00000180, angle_tick_position);
        check("accum_range", 32'h1,
            {31'h0, accumulated_tooth_interval inside {[48:56]}});
        $display("test sync finished");
        run = 1'b0;
        repeat (800) @(negedge ref_clk);
        check("sync_lost_indicator", 32'h1, {31'h0, sync_lost_indicator});
        check("crank_tooth_index", 32'h0, {16'h0, crank_tooth_index});
        check("angle_tick_position", 32'h0, angle_tick_position);
        check("tooth_interval", 32'h0, tooth_interval);
        tracking_allow = 1'b0;
        run = 1'b1;
        revs(3);
        check("sync_lost_indicator", 32'h1, {31'h0, sync_lost_indicator});
        tracking_allow = 1'b1;
        wait_lost(1'b0);
        $display("test stall_restart finished");
        wait_pos(16'h0000);
        skip = 1'b1;
        wait_pos(16'h0003);
        skip = 1'b0;
        revs(1);
        check("missing_flag", 32'h1, {31'h0, pattern_error_flag[`ESS_ERR_MISSING]});
        clear_flags();
        wait_lost(1'b0);
        wait_pos(16'h0000);
        no_cam = 1'b1;
        revs(1);
        no_cam = 1'b0;
        revs(1);
        check("cam_flag", 32'h1, {31'h0, pattern_error_flag[`ESS_ERR_CAM]});
        clear_flags();
        wait_lost(1'b0);
        wait_pos(16'h0006);
        fill = 1'b1;
        wait_pos(16'h0000);
        fill = 1'b0;
        revs(1);
        check("extra_flag", 32'h1, {31'h0, pattern_error_flag[`ESS_ERR_EXTRA]});
        clear_flags();
        filter_enable = 1'b1;
        wait_lost(1'b0);
        $display("test errors finished");
        glitch = 1'b1;
        revs(3);
        check("pattern_error_flag", 32'h0, {29'h0, pattern_error_flag});
        check("sync_lost_indicator", 32'h0, {31'h0, sync_lost_indicator});
        filter_enable = 1'b0;
        revs(2);
        check("glitch_error", 32'h1, {31'h0, |pattern_error_flag});
        glitch = 1'b0;
        $display("test filter finished");
        report_and_stop();
    end
endmodule
`default_nettype wire
